// >>> hdl/ise_pkg.sv
package ise_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int unsigned NUM_LINES  = 64;
    localparam int unsigned WORD_BITS  = 32;
    localparam int unsigned ADDR_BITS  = 8;
    localparam int unsigned PRIO_BITS  = 4;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_ENABLE_SET_LOW  = 8'h00;
    localparam logic [7:0] OFF_ENABLE_SET_HIGH = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS      = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK        = 8'h0C;
    localparam logic [7:0] OFF_PENDING_LOW     = 8'h10;
    localparam logic [7:0] OFF_PENDING_HIGH    = 8'h14;
    localparam logic [7:0] OFF_ACTIVE_STATE    = 8'h18;
    localparam logic [7:0] OFF_ACK             = 8'h1C;
    localparam logic [7:0] OFF_PRIO_BASE       = 8'h40;

    // ----------------------------------------
    // Reset values and fields
    // ----------------------------------------
    localparam logic [31:0] RST_ENABLE_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_MASK_WORD   = 32'h0000_0000;
    localparam logic [3:0]  RST_PRIO        = 4'h0;
    localparam int unsigned STS_ACTIVATED   = 0;
    localparam int unsigned STS_BLOCKED     = 1;
    localparam int unsigned STS_BITS        = 2;
    localparam int unsigned ACT_VALID_BIT   = 31;

endpackage

// >>> hdl/ise_prio_mem.sv
`timescale 1ns/1ps
module ise_prio_mem
    import ise_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // Write port
    input  wire logic                 wrEn,
    input  wire logic [5:0]           wrAddr,
    input  wire logic [PRIO_BITS-1:0] wrData,
    // Read port
    input  wire logic [5:0]           rdAddr,
    output logic      [PRIO_BITS-1:0] rdData,
    // Whole table for arbitration
    output logic      [NUM_LINES*PRIO_BITS-1:0] prioAll
);
    import ise_pkg::*;

    logic [PRIO_BITS-1:0] memReg  [NUM_LINES];
    logic [PRIO_BITS-1:0] memNext [NUM_LINES];
    logic [PRIO_BITS-1:0] rdReg;
    logic [PRIO_BITS-1:0] rdNext;

    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            memNext[i] = memReg[i];
            prioAll[i*PRIO_BITS +: PRIO_BITS] = memReg[i];
        end
        if (wrEn) begin
            memNext[wrAddr] = wrData;
        end
        rdNext = memReg[rdAddr];
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_LINES; i++) begin
                memReg[i] <= RST_PRIO;
            end
            rdReg <= RST_PRIO;
        end else begin
            memReg <= memNext;
            rdReg  <= rdNext;
        end
    end

    assign rdData = rdReg;
endmodule

// >>> hdl/ise_set_enable.sv
`timescale 1ns/1ps
// How it works
// - Write one sets enable, zero ignored
// - Read returns current enable bits
// - Pending and enabled line activates by priority
// - Disabled line request still becomes pending
// - Disabled line is never activated
module ise_set_enable
    import ise_pkg::*;
(
    // Clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst_b,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ise_pkg::ADDR_BITS-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Interrupt request lines
    input  wire logic [ise_pkg::NUM_LINES-1:0] irqLines,
    // Core side
    output logic                              coreIrq,
    output logic      [5:0]                   activeLine,
    output logic                              irq
);
    import ise_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [NUM_LINES-1:0] lineSync1Reg, lineSyncReg, linePrevReg;
    logic [NUM_LINES-1:0] enableReg, enableNext;
    logic [NUM_LINES-1:0] pendReg, pendNext;
    logic                 actValidReg, actValidNext;
    logic [5:0]           actLineReg, actLineNext;
    logic [STS_BITS-1:0]  stsReg, stsNext;
    logic [STS_BITS-1:0]  maskReg, maskNext;
    logic [31:0]          rdataReg, rdataNext;
    logic                 readyReg, readyNext;
    logic                 errReg, errNext;
    logic                 irqReg, irqNext;
    logic                 prioWr;
    logic [5:0]           prioAddr;
    logic [PRIO_BITS-1:0] prioRd;
    logic [NUM_LINES*PRIO_BITS-1:0] prioTable;
    logic                 winValid;
    logic [5:0]           winLine;
    logic [PRIO_BITS-1:0] winPrio;
    logic                 blockedEvt;

    function automatic logic word_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ----------------------------------------
    // Priority table
    // ----------------------------------------
    wire  access  = psel && penable && !readyReg;
    wire  wrAcc   = access && pwrite;
    // Compare in 9 bits: the table end lies past the 8-bit bus, so lines 48 and up get no slot
    wire  prioHit = ({1'b0, paddr} >= {1'b0, OFF_PRIO_BASE}) &&
                    ({1'b0, paddr} < ({1'b0, OFF_PRIO_BASE} + 9'(NUM_LINES * 4)));
    assign prioWr   = wrAcc && prioHit;
    assign prioAddr = 6'((paddr - OFF_PRIO_BASE) >> 2);

    ise_prio_mem u_prio (
        .clock  (clock),
        .rst_b  (rst_b),
        .wrEn   (prioWr),
        .wrAddr (prioAddr),
        .wrData (pwdata[PRIO_BITS-1:0]),
        .rdAddr (prioAddr),
        .rdData (prioRd),
        .prioAll(prioTable)
    );

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    always_comb begin
        winValid = 1'b0;
        winLine  = 6'h0;
        winPrio  = '1;
        // Lower value wins; ties go to lower line number
        for (int i = 0; i < NUM_LINES; i++) begin
            if (pendReg[i] && enableReg[i] &&
                (!winValid || prioTable[i*PRIO_BITS +: PRIO_BITS] < winPrio)) begin
                winValid = 1'b1;
                winLine  = 6'(i);
                winPrio  = prioTable[i*PRIO_BITS +: PRIO_BITS];
            end
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [NUM_LINES-1:0] rise;
        logic [NUM_LINES-1:0] setMask;
        logic [NUM_LINES-1:0] ackMask;
        rise       = lineSyncReg & ~linePrevReg;
        setMask    = '0;
        ackMask    = '0;
        enableNext = enableReg;
        maskNext   = maskReg;
        rdataNext  = rdataReg;
        readyNext  = access;
        errNext    = 1'b0;
        actValidNext = actValidReg;
        actLineNext  = actLineReg;
        blockedEvt   = |(rise & ~enableReg);
        if (wrAcc) begin
            if (word_hit(paddr, OFF_ENABLE_SET_LOW))  setMask[31:0]  = pwdata;
            if (word_hit(paddr, OFF_ENABLE_SET_HIGH)) setMask[63:32] = pwdata;
            if (word_hit(paddr, OFF_IRQ_MASK)) maskNext = pwdata[STS_BITS-1:0];
            if (word_hit(paddr, OFF_ACK) && actValidReg) begin
                actValidNext = 1'b0;
                ackMask[actLineReg] = 1'b1;
            end
        end
        enableNext = enableReg | setMask;
        // Edge pends regardless of enable
        pendNext = (pendReg & ~ackMask) | rise;
        if (!actValidReg && winValid) begin
            actValidNext = 1'b1;
            actLineNext  = winLine;
        end
        // Set beats write-one clear
        stsNext = stsReg;
        if (wrAcc && word_hit(paddr, OFF_IRQ_STATUS)) stsNext = stsReg & ~pwdata[STS_BITS-1:0];
        if (!actValidReg && winValid) stsNext[STS_ACTIVATED] = 1'b1;
        if (blockedEvt) stsNext[STS_BLOCKED] = 1'b1;
        if (access && !pwrite) begin
            unique case (1'b1)
                word_hit(paddr, OFF_ENABLE_SET_LOW):  rdataNext = enableReg[31:0];
                word_hit(paddr, OFF_ENABLE_SET_HIGH): rdataNext = enableReg[63:32];
                word_hit(paddr, OFF_IRQ_STATUS):   rdataNext = 32'(stsReg);
                word_hit(paddr, OFF_IRQ_MASK):     rdataNext = 32'(maskReg);
                word_hit(paddr, OFF_PENDING_LOW):  rdataNext = pendReg[31:0];
                word_hit(paddr, OFF_PENDING_HIGH): rdataNext = pendReg[63:32];
                word_hit(paddr, OFF_ACTIVE_STATE): rdataNext = {actValidReg, 25'h0, actLineReg};
                prioHit:                           rdataNext = 32'(prioRd);
                default: begin
                    rdataNext = 32'h0000_0000;
                    errNext   = 1'b1;
                end
            endcase
        end else if (wrAcc) begin
            rdataNext = 32'h0000_0000;
            errNext = !(word_hit(paddr, OFF_ENABLE_SET_LOW) || word_hit(paddr, OFF_ENABLE_SET_HIGH) ||
                        word_hit(paddr, OFF_IRQ_STATUS) || word_hit(paddr, OFF_IRQ_MASK) ||
                        word_hit(paddr, OFF_ACK) || prioHit);
        end
        irqNext = |(stsNext & maskNext);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        // Two-flop synchroniser on external request lines
        lineSync1Reg <= irqLines;
        lineSyncReg  <= lineSync1Reg;
        if (!rst_b) begin
            linePrevReg <= '0;
            enableReg   <= {RST_ENABLE_WORD, RST_ENABLE_WORD};
            pendReg     <= '0;
            actValidReg <= 1'b0;
            actLineReg  <= 6'h0;
            stsReg      <= '0;
            maskReg     <= RST_MASK_WORD[STS_BITS-1:0];
            rdataReg    <= 32'h0000_0000;
            readyReg    <= 1'b0;
            errReg      <= 1'b0;
            irqReg      <= 1'b0;
        end else begin
            linePrevReg <= lineSyncReg;
            enableReg   <= enableNext;
            pendReg     <= pendNext;
            actValidReg <= actValidNext;
            actLineReg  <= actLineNext;
            stsReg      <= stsNext;
            maskReg     <= maskNext;
            rdataReg    <= rdataNext;
            readyReg    <= readyNext;
            errReg      <= errNext;
            irqReg      <= irqNext;
        end
    end

    assign prdata     = rdataReg;
    assign pready     = readyReg;
    assign pslverr    = errReg;
    assign coreIrq    = actValidReg;
    assign activeLine = actLineReg;
    assign irq        = irqReg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [NUM_LINES-1:0] blockedRise;
    assign blockedRise = lineSyncReg & ~linePrevReg & ~enableReg;

    sequence s_setWrite;
        wrAcc && word_hit(paddr, OFF_ENABLE_SET_LOW);
    endsequence

    property p_setOne;
        @(posedge clock) disable iff (!rst_b)
        s_setWrite |=> ((enableReg[31:0] & $past(pwdata)) == $past(pwdata));
    endproperty
    a_setOne: assert property (p_setOne) else $error("set write lost a bit");

    property p_zeroKeeps;
        @(posedge clock) disable iff (!rst_b)
        1'b1 |=> ((enableReg & $past(enableReg)) == $past(enableReg));
    endproperty
    a_zeroKeeps: assert property (p_zeroKeeps) else $error("enable bit cleared");

    property p_readLow;
        @(posedge clock) disable iff (!rst_b)
        (access && !pwrite && word_hit(paddr, OFF_ENABLE_SET_LOW)) |=> (prdata == $past(enableReg[31:0]));
    endproperty
    a_readLow: assert property (p_readLow) else $error("enable readback wrong");

    property p_readHigh;
        @(posedge clock) disable iff (!rst_b)
        (access && !pwrite && word_hit(paddr, OFF_ENABLE_SET_HIGH)) |=> (prdata == $past(enableReg[63:32]));
    endproperty
    a_readHigh: assert property (p_readHigh) else $error("high readback wrong");

    property p_activates;
        @(posedge clock) disable iff (!rst_b)
        (!actValidReg && winValid) |=> (actValidReg && actLineReg == $past(winLine));
    endproperty
    a_activates: assert property (p_activates) else $error("eligible line not activated");

    property p_pendDisabled;
        @(posedge clock) disable iff (!rst_b)
        (blockedRise != '0) |=> ((pendReg & $past(blockedRise)) == $past(blockedRise));
    endproperty
    a_pendDisabled: assert property (p_pendDisabled) else $error("disabled request not pended");

    property p_neverDisabled;
        @(posedge clock) disable iff (!rst_b)
        // Enables never clear, so an active line must still be enabled
        coreIrq |-> enableReg[activeLine];
    endproperty
    a_neverDisabled: assert property (p_neverDisabled) else $error("disabled line activated");

    property p_irqLevel;
        @(posedge clock) disable iff (!rst_b)
        1'b1 |-> (irq == |(stsReg & maskReg));
    endproperty
    a_irqLevel: assert property (p_irqLevel) else $error("irq level mismatch");
endmodule

// >>> tb/ise_irq_peer.sv
`timescale 1ns/1ps
// Peripheral request lines; a raised line stays up until dropped
module ise_irq_peer (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Bench control
    input  wire logic [63:0] raiseMask,
    input  wire logic [63:0] dropMask,
    // Lines to the block
    output logic      [63:0] irqLines
);
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irqLines <= 64'h0000_0000_0000_0000;
        end else begin
            irqLines <= (irqLines | raiseMask) & ~dropMask;
        end
    end
endmodule

// >>> tb/tb_interrupt_set_enable_logic.sv
`timescale 1ns/1ps
module tb_interrupt_set_enable_logic;
    import ise_pkg::*;
    logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, coreIrq, irq, err;
    logic [5:0]  activeLine;
    logic [63:0] irqLines, raiseMask = '0, dropMask = '0;
    int          n_mismatch = 0, n_checks = 0, cycles = 0;

    ise_set_enable dut_u (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irqLines(irqLines), .coreIrq(coreIrq), .activeLine(activeLine),
        .irq(irq));
    ise_irq_peer peer_u (.clock(clock), .rst_b(rst_b), .raiseMask(raiseMask),
        .dropMask(dropMask), .irqLines(irqLines));

    initial begin
        forever #20 clock = ~clock;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic raise(input logic [63:0] m);
        @(posedge clock);
        raiseMask <= m;
        @(posedge clock);
        raiseMask <= '0;
    endtask

    // Bounded wait for a given line to be active
    task automatic wait_line(input logic [5:0] line);
        logic seen;
        seen = 0;
        repeat (20) begin
            @(posedge clock);
            if (coreIrq === 1'b1 && activeLine === line) seen = 1;
        end
        check({31'h0, seen}, 32'h0000_0001);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_reset_and_map();
        apb(0, OFF_ENABLE_SET_LOW, 0);  check(rd, RST_ENABLE_WORD);
        apb(0, OFF_ENABLE_SET_HIGH, 0); check(rd, RST_ENABLE_WORD);
        apb(1, 8'h30, 32'hFFFF_FFFF);   check({31'h0, err}, 32'h0000_0001);
        apb(0, 8'h30, 0);               check(rd, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
    endtask

    task automatic sc_write_one_sets();
        apb(1, OFF_ENABLE_SET_LOW, 32'h0000_00A5);
        apb(1, OFF_ENABLE_SET_LOW, 32'h0000_0000);
        apb(0, OFF_ENABLE_SET_LOW, 0);  check(rd, 32'h0000_00A5);
        apb(1, OFF_ENABLE_SET_HIGH, 32'h8000_0001);
        apb(0, OFF_ENABLE_SET_HIGH, 0); check(rd, 32'h8000_0001);
        apb(0, OFF_ENABLE_SET_LOW, 0);  check(rd, 32'h0000_00A5);
    endtask

    // Line 40 is disabled: pending, flagged, never active
    task automatic sc_disabled_line();
        apb(1, OFF_IRQ_MASK, 32'h0000_0002);
        raise(64'h0000_0100_0000_0000);
        repeat (8) @(posedge clock);
        check({31'h0, coreIrq}, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0001);
        apb(0, OFF_PENDING_HIGH, 0);    check(rd, 32'h0000_0100);
        apb(0, OFF_ACTIVE_STATE, 0);    check(rd, 32'h0000_0000);
        apb(1, OFF_IRQ_STATUS, 32'h0000_0003);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1, OFF_IRQ_MASK, 32'h0000_0000);
    endtask

    // Lower priority value wins; ack hands over to the next line
    task automatic sc_priority();
        apb(1, 8'h40, 32'h0000_0003);
        apb(1, 8'h48, 32'h0000_0001);
        raise(64'h0000_0000_0000_0005);
        wait_line(6'd2);
        apb(0, OFF_ACTIVE_STATE, 0);    check(rd, 32'h8000_0002);
        apb(1, OFF_ACK, 0);
        wait_line(6'd0);
        apb(1, OFF_ACK, 0);
        repeat (4) @(posedge clock);
        check({31'h0, coreIrq}, 32'h0000_0000);
        // Enabling the still pending line 40 activates it
        apb(1, OFF_ENABLE_SET_HIGH, 32'h0000_0100);
        wait_line(6'd40);
        apb(0, OFF_ENABLE_SET_HIGH, 0); check(rd, 32'h8000_0101);
        apb(1, OFF_ACK, 0);
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1;
        sc_reset_and_map();
        sc_write_one_sets();
        sc_disabled_line();
        sc_priority();
        complete_run();
    end
endmodule
